// file: verilog/spc_core.sv
// serial peripheral port, host or client, with axi4-lite registers
// assumes spi pins and select are synchronous to clk; pin wires resolved outside
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.svh"
// Summary of operation
// RULE_01 - data is driven on one clock edge and sampled on the opposite one
// RULE_02 - modes 0 and 1: rising leading edge, sample first or set up first
// RULE_03 - modes 2 and 3: falling leading edge, sample first or set up first
// RULE_04 - idle clock level is low for rising leading edge, high otherwise
// RULE_05 - host clock is given out as a level event held two clocks minimum
// RULE_06 - unbuffered interrupt comes from transfer complete and write collision
// RULE_07 - buffered interrupt comes from select, buffer empty, transfer and receive
// RULE_08 - interrupt stays high while a flag and its enable are both set
// RULE_09 - bit order zero sends msb first, one sends lsb first
// RULE_10 - host loses mastership when select goes low, setting transfer complete; buffered mode sets the select trigger flag instead
// RULE_11 - select disable makes host mode ignore the select input
// RULE_12 - prescaler divides peripheral clock by 4, 16, 64 or 128
// RULE_13 - prescaler and doubling do nothing in client mode
// RULE_14 - clock double bit doubles the prescaled host clock rate
// RULE_15 - buffer enable adds two receive slots and one transmit slot
// RULE_16 - wait bit zero: one transfer completes before written data is shifted
// RULE_17 - wait bit one: first write while deselected loads the shifter directly
// RULE_18 - unbuffered write during a transfer is dropped and flags a collision
// RULE_19 - client deselect resets the transfer at once, dropping partial bytes
// RULE_20 - host data write starts a transfer; client write only prepares it
// RULE_21 - receive complete rises one cycle after buffer empty at transfer end
// RULE_22 - each transfer is eight clock cycles, one byte each way
module spc_core import spc_pkg::*; #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic select_b_in,
  // event and interrupt
  output logic sck_event,
  output logic irq
);
  spc_core_t cur, next_cur;
  logic reg_we, reg_re;
  logic [2:0] reg_widx, reg_ridx;
  logic [7:0] reg_wdata, rd_data;
  logic host, en, bufm, cpha, cpol, lsb, sck_eff, edg, samp_e, setup_e, in_bit, done, go;

  spc_axil #(.AW(AW)) u_bus (
    .clk(clk), .rst_b(rst_b),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .reg_we(reg_we), .reg_widx(reg_widx), .reg_wdata(reg_wdata),
    .reg_re(reg_re), .reg_ridx(reg_ridx), .reg_rdata(rd_data)
  );

  function automatic logic first_bit(input logic [7:0] d, input logic lsb_first);
    first_bit = lsb_first ? d[0] : d[7]; // [RULE_09]
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b}; // [RULE_09]
  endfunction

  // reload value of the half-period counter
  function automatic logic [6:0] half_rel(input logic [1:0] pre, input logic dbl);
    logic [6:0] h;
    if (pre == `SPC_PRE_D4) begin
      h = `SPC_HALF_D4; // [RULE_12]
    end else if (pre == `SPC_PRE_D16) begin
      h = `SPC_HALF_D16;
    end else if (pre == `SPC_PRE_D64) begin
      h = `SPC_HALF_D64;
    end else begin
      h = `SPC_HALF_D128;
    end
    half_rel = (h >> dbl) - 7'h01; // [RULE_14]
  endfunction

  always_comb begin
    next_cur = cur;
    host = cur.ctla[`SPC_A_HOST];
    en = cur.ctla[`SPC_A_EN];
    bufm = cur.ctlb[`SPC_B_BUF];
    cpha = cur.ctlb[`SPC_B_CPHA];
    cpol = cur.ctlb[`SPC_B_CPOL];
    lsb = cur.ctla[`SPC_A_ORD];
    sck_eff = host ? cur.sck : sck_in; // [RULE_13]
    edg = sck_eff ^ cur.sck_q;
    samp_e = edg & (sck_eff ^ cpol ^ cpha); // [RULE_01] [RULE_02] [RULE_03]
    setup_e = edg & ~(sck_eff ^ cpol ^ cpha);
    in_bit = host ? miso_in : mosi_in;
    done = 1'b0;
    go = 1'b0;
    rd_data = `SPC_RST8;
    next_cur.sck_q = sck_eff;
    // register reads
    if (reg_re) begin
      if (reg_ridx == `SPC_IDX_CTLA) begin
        rd_data = cur.ctla;
      end else if (reg_ridx == `SPC_IDX_CTLB) begin
        rd_data = cur.ctlb;
      end else if (reg_ridx == `SPC_IDX_INTEN) begin
        rd_data = cur.inten;
      end else if (reg_ridx == `SPC_IDX_FLAGS) begin
        if (bufm) begin
          rd_data = {cur.rxcnt != 2'h0, cur.transfer_complete_flag, cur.transmit_buffer_empty_flag, cur.select_trigger_flag, 3'h0, cur.ovf};
        end else begin
          rd_data = {cur.flg_if, cur.write_collision_flag, 6'h00};
          next_cur.arm_if = cur.flg_if;
          next_cur.arm_wc = cur.write_collision_flag;
        end
      end else begin
        rd_data = bufm ? cur.rxb0 : cur.rxd;
        if (bufm) begin
          next_cur.ovf = 1'b0;
          if (cur.rxcnt != 2'h0) begin
            next_cur.rxb0 = cur.rxb1;
            next_cur.rxcnt = cur.rxcnt - 2'h1;
          end
        end
      end
    end
    // reading flags then touching data clears the unbuffered flags
    if ((reg_re && reg_ridx == `SPC_IDX_DATA) || (reg_we && reg_widx == `SPC_IDX_DATA)) begin
      if (cur.arm_if) begin
        next_cur.flg_if = 1'b0;
      end
      if (cur.arm_wc) begin
        next_cur.write_collision_flag = 1'b0;
      end
      next_cur.arm_if = 1'b0;
      next_cur.arm_wc = 1'b0;
    end
    // register writes
    if (reg_we) begin
      if (reg_widx == `SPC_IDX_CTLA) begin
        next_cur.ctla = reg_wdata & `SPC_A_MASK;
      end else if (reg_widx == `SPC_IDX_CTLB) begin
        next_cur.ctlb = reg_wdata & `SPC_B_MASK;
      end else if (reg_widx == `SPC_IDX_INTEN) begin
        next_cur.inten = reg_wdata & `SPC_I_MASK;
      end else if (reg_widx == `SPC_IDX_FLAGS) begin
        if (bufm) begin
          if (reg_wdata[`SPC_F_TXC]) next_cur.transfer_complete_flag = 1'b0;
          if (reg_wdata[`SPC_F_SS]) next_cur.select_trigger_flag = 1'b0;
          if (reg_wdata[`SPC_F_OVF]) next_cur.ovf = 1'b0;
          if (reg_wdata[`SPC_F_RXC]) next_cur.rxcnt = 2'h0;
        end
      end else if (!bufm) begin
        if (cur.st == st_run) begin
          next_cur.write_collision_flag = 1'b1; // [RULE_18]
        end else begin
          next_cur.shreg = reg_wdata;
          go = 1'b1; // [RULE_20]
        end
      end else if (!cur.txfull) begin
        if (cur.ctlb[`SPC_B_WFR] && cur.st == st_idle && en && (host || select_b_in)
            && !cur.shfull) begin
          next_cur.shreg = reg_wdata; // [RULE_17]
          next_cur.shfull = 1'b1;
          go = 1'b1;
        end else begin
          next_cur.txbuf = reg_wdata; // [RULE_15]
          next_cur.txfull = 1'b1;
          next_cur.transmit_buffer_empty_flag = 1'b0;
        end
      end
    end
    // buffered host sends the shifter contents first as a dummy byte
    if (bufm && cur.st == st_idle && cur.txfull) begin
      go = 1'b1; // [RULE_16]
    end
    // shift engine
    case (cur.st)
      st_run: begin
        if (samp_e) begin
          next_cur.shreg = shift_in(cur.shreg, in_bit, lsb); // [RULE_01]
          next_cur.nbit = cur.nbit + 4'h1;
        end
        if (setup_e && !host) begin
          next_cur.mo = first_bit(cur.shreg, lsb);
        end
        if (host) begin
          if (cur.div == 7'h00) begin
            if (cur.tog != `SPC_TOG_CNT) begin
              next_cur.sck = ~cur.sck;
              next_cur.tog = cur.tog + 5'h01;
              if (!(next_cur.sck ^ cpol ^ cpha)) next_cur.mo = first_bit(next_cur.shreg, lsb);
            end
            next_cur.div = half_rel(cur.ctla[`SPC_A_PRE], cur.ctla[`SPC_A_DBL]); // [RULE_12]
          end else begin
            next_cur.div = cur.div - 7'h01;
          end
          done = (cur.tog == `SPC_TOG_CNT) && !edg; // [RULE_22]
        end else begin
          done = (cur.nbit == `SPC_BIT_CNT); // [RULE_22]
        end
      end
      default: begin
        if (!host && en && !select_b_in) begin
          next_cur.st = st_run;
          next_cur.nbit = 4'h0;
          next_cur.mo = first_bit(next_cur.shreg, lsb);
          next_cur.shfull = 1'b0;
        end
      end
    endcase
    // end of a byte
    if (done) begin
      next_cur.st = st_idle;
      if (!bufm) begin
        next_cur.flg_if = 1'b1; // [RULE_06]
        next_cur.rxd = cur.shreg;
      end else begin
        next_cur.push = 1'b1;
        next_cur.pdat = cur.shreg;
        if (next_cur.txfull) begin
          next_cur.shreg = next_cur.txbuf; // [RULE_16]
          next_cur.txfull = 1'b0;
          next_cur.transmit_buffer_empty_flag = 1'b1;
          go = 1'b1;
        end else begin
          next_cur.txcp = 1'b1;
        end
      end
    end
    // received byte enters the receive slots one cycle later
    if (cur.push) begin
      next_cur.push = 1'b0;
      next_cur.txcp = 1'b0;
      if (cur.txcp) next_cur.transfer_complete_flag = 1'b1;
      if (next_cur.rxcnt == 2'h2) begin
        next_cur.ovf = 1'b1;
      end else begin
        if (next_cur.rxcnt == 2'h0) begin
          next_cur.rxb0 = cur.pdat; // [RULE_21]
        end else begin
          next_cur.rxb1 = cur.pdat;
        end
        next_cur.rxcnt = next_cur.rxcnt + 2'h1;
      end
    end
    // select pulled low while host
    if (en && host && !cur.ctlb[`SPC_B_SSD] && !select_b_in) begin // [RULE_11]
      next_cur.ctla[`SPC_A_HOST] = 1'b0; // [RULE_10]
      next_cur.st = st_idle;
      if (bufm) begin
        next_cur.select_trigger_flag = 1'b1;
      end else begin
        next_cur.flg_if = 1'b1; // [RULE_10]
      end
    end
    if (!host && select_b_in) begin
      next_cur.st = st_idle; // [RULE_19]
      next_cur.nbit = 4'h0;
    end
    if (!en) begin
      next_cur.st = st_idle;
    end
    // host transfer start
    if (go && next_cur.ctla[`SPC_A_HOST] && en) begin
      next_cur.st = st_run; // [RULE_20]
      next_cur.sck = cpol;
      next_cur.div = half_rel(cur.ctla[`SPC_A_PRE], cur.ctla[`SPC_A_DBL]);
      next_cur.tog = 5'h00;
      next_cur.nbit = 4'h0;
      next_cur.mo = first_bit(next_cur.shreg, lsb);
      next_cur.shfull = 1'b0;
    end else if (next_cur.st == st_idle) begin
      next_cur.sck = cpol; // [RULE_04]
    end
    // clock event, each level held two clocks at least
    if ((cur.ev != cur.sck) && cur.ev_age) begin
      next_cur.ev = cur.sck; // [RULE_05]
      next_cur.ev_age = 1'b0;
    end else begin
      next_cur.ev_age = 1'b1;
    end
    if (next_cur.ctlb[`SPC_B_BUF]) begin
      next_cur.irq = |(next_cur.inten[`SPC_I_BUF] & {next_cur.rxcnt != 2'h0, next_cur.transfer_complete_flag,
                                               next_cur.transmit_buffer_empty_flag, next_cur.select_trigger_flag}); // [RULE_07]
    end else begin
      next_cur.irq = next_cur.inten[`SPC_F_IE] & (next_cur.flg_if | next_cur.write_collision_flag); // [RULE_08]
    end
    next_cur.sck_oe = next_cur.ctla[`SPC_A_EN] & next_cur.ctla[`SPC_A_HOST];
    next_cur.mosi_oe = next_cur.sck_oe;
    next_cur.miso_oe = next_cur.ctla[`SPC_A_EN] & ~next_cur.ctla[`SPC_A_HOST] & ~select_b_in;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sck_out = cur.sck;
  assign sck_oe = cur.sck_oe;
  assign mosi_out = cur.mo;
  assign mosi_oe = cur.mosi_oe;
  assign miso_out = cur.mo;
  assign miso_oe = cur.miso_oe;
  assign sck_event = cur.ev;
  assign irq = cur.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence seq_dre_then_rxc;
    cur.transmit_buffer_empty_flag ##1 (cur.rxcnt != 2'h0 || cur.ovf);
  endsequence
  sequence seq_dre_irq_held;
    (bufm && cur.inten[`SPC_F_DRE] && cur.transmit_buffer_empty_flag) [*2];
  endsequence

  a_idle_clock_level: assert property ( // [RULE_04]
    cur.st == st_idle && $past(cur.st == st_idle) && $stable(cur.ctlb) |-> cur.sck == cpol)
    else $error("serial clock not at idle level");
  a_event_hold: assert property ($changed(cur.ev) |=> $stable(cur.ev)) // [RULE_05]
    else $error("clock event level held under two cycles");
  a_irq_unbuf: assert property ( // [RULE_06]
    (!bufm && cur.inten[`SPC_F_IE] && cur.flg_if) [*2] |-> cur.irq)
    else $error("unbuffered interrupt missing");
  a_irq_level: assert property (seq_dre_irq_held |-> cur.irq) // [RULE_08]
    else $error("interrupt dropped while flag and enable set");
  a_host_loss: assert property ( // [RULE_10]
    en && host && !cur.ctlb[`SPC_B_SSD] && !select_b_in
    |=> !cur.ctla[`SPC_A_HOST] && (cur.flg_if || cur.select_trigger_flag))
    else $error("host mode kept after select went low");
  a_ssd_keeps_host: assert property ( // [RULE_11]
    en && host && cur.ctlb[`SPC_B_SSD] && !(reg_we && reg_widx == `SPC_IDX_CTLA)
    |=> cur.ctla[`SPC_A_HOST])
    else $error("host mode dropped with select disabled");
  a_write_collision_flag_busy: assert property ( // [RULE_18]
    reg_we && reg_widx == `SPC_IDX_DATA && !bufm && cur.st == st_run
    |=> cur.write_collision_flag && cur.tog >= $past(cur.tog) || cur.st != st_run)
    else $error("write during transfer not flagged");
  a_client_abort: assert property (!host && select_b_in |=> cur.st == st_idle) // [RULE_19]
    else $error("client transfer not reset on deselect");
  a_host_start: assert property ( // [RULE_20]
    reg_we && reg_widx == `SPC_IDX_DATA && !bufm && host && en && cur.st == st_idle
    && (cur.ctlb[`SPC_B_SSD] || select_b_in) |=> cur.st == st_run && cur.tog == 5'h00)
    else $error("host data write did not start a transfer");
  a_rxc_after_dre: assert property ( // [RULE_21]
    done && bufm && cur.txfull |=> seq_dre_then_rxc)
    else $error("receive complete not one cycle after buffer empty");
  a_byte_length: assert property (done |-> cur.nbit == `SPC_BIT_CNT) // [RULE_22]
    else $error("transfer ended with wrong bit count");
endmodule
`default_nettype wire

// file: verilog/spc_consts.svh
// register indices, field positions, reset values and divider counts
// assumes inclusion by every file of the serial port core
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
// register indices; byte address is four times the index
`define SPC_IDX_CTLA 3'h0
`define SPC_IDX_CTLB 3'h1
`define SPC_IDX_INTEN 3'h2
`define SPC_IDX_FLAGS 3'h3
`define SPC_IDX_DATA 3'h4
`define SPC_IDX_LAST 3'h4
`define SPC_RST8 8'h00
// control_a fields
`define SPC_A_EN 0
`define SPC_A_DBL 4
`define SPC_A_HOST 5
`define SPC_A_ORD 6
`define SPC_A_PRE 2:1
`define SPC_A_MASK 8'h77
// control_b fields
`define SPC_B_CPHA 0
`define SPC_B_CPOL 1
`define SPC_B_SSD 2
`define SPC_B_WFR 6
`define SPC_B_BUF 7
`define SPC_B_MASK 8'hc7
// flag and enable positions
`define SPC_F_IF 7
`define SPC_F_WRITE_COLLISION_FLAG 6
`define SPC_F_RXC 7
`define SPC_F_TXC 6
`define SPC_F_DRE 5
`define SPC_F_SS 4
`define SPC_F_OVF 0
`define SPC_F_IE 0
`define SPC_I_MASK 8'hf1
`define SPC_I_BUF 7:4
// prescaler codes and half periods in peripheral clocks
`define SPC_PRE_D4 2'h0
`define SPC_PRE_D16 2'h1
`define SPC_PRE_D64 2'h2
`define SPC_HALF_D4 7'h02
`define SPC_HALF_D16 7'h08
`define SPC_HALF_D64 7'h20
`define SPC_HALF_D128 7'h40
// transfer shape
`define SPC_BIT_CNT 4'h8
`define SPC_TOG_CNT 5'h10
// bus answers
`define SPC_RESP_OK 2'h0
`define SPC_RESP_ERR 2'h2
`endif

// file: verilog/spc_pkg.sv
// state types of the serial port core and its bus slave
// assumes nothing beyond a SystemVerilog compiler
package spc_pkg;
  typedef enum logic [1:0] {st_idle = 2'b01, st_run = 2'b10} spc_state_t;
  typedef struct packed {
    logic [7:0] ctla, ctlb, inten;
    spc_state_t st;
    logic [6:0] div;
    logic [4:0] tog;
    logic [3:0] nbit;
    logic sck, sck_q, mo;
    logic [7:0] shreg, rxd, rxb0, rxb1, txbuf, pdat;
    logic [1:0] rxcnt;
    logic txfull, shfull, flg_if, write_collision_flag, arm_if, arm_wc, transfer_complete_flag, transmit_buffer_empty_flag, select_trigger_flag, ovf, push, txcp;
    logic ev, ev_age, irq, sck_oe, mosi_oe, miso_oe;
  } spc_core_t;
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid, aw_h, w_h, aok, wlane, rpend, we, re;
    logic [1:0] bresp, rresp;
    logic [2:0] widx, ridx;
    logic [7:0] wd, rdata;
  } spc_bus_t;
endpackage

// file: verilog/spc_axil.sv
// axi4-lite slave turning bus accesses into one-cycle register strobes
// assumes a single clock; read data is returned by the core combinationally
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.svh"
module spc_axil import spc_pkg::*; #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register strobes
  output logic reg_we,
  output logic [2:0] reg_widx,
  output logic [7:0] reg_wdata,
  output logic reg_re,
  output logic [2:0] reg_ridx,
  input wire logic [7:0] reg_rdata
);
  spc_bus_t cur, next_cur;

  function automatic logic hit(input logic [AW-1:0] a);
    hit = (a[AW-1:2] <= (AW-2)'(`SPC_IDX_LAST));
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.we = 1'b0;
    next_cur.re = 1'b0;
    if (awvalid && cur.awready) begin
      next_cur.aw_h = 1'b1;
      next_cur.widx = awaddr[4:2];
      next_cur.aok = hit(awaddr);
    end
    if (wvalid && cur.wready) begin
      next_cur.w_h = 1'b1;
      next_cur.wd = wdata[7:0];
      next_cur.wlane = wstrb[0];
    end
    if (bready && cur.bvalid) begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.aw_h && cur.w_h && !cur.bvalid) begin
      next_cur.aw_h = 1'b0;
      next_cur.w_h = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = cur.aok ? `SPC_RESP_OK : `SPC_RESP_ERR;
      next_cur.we = cur.aok & cur.wlane;
    end
    if (arvalid && cur.arready) begin
      next_cur.ridx = araddr[4:2];
      next_cur.re = hit(araddr);
      next_cur.rresp = hit(araddr) ? `SPC_RESP_OK : `SPC_RESP_ERR;
      next_cur.rpend = 1'b1;
    end
    if (cur.rpend) begin
      next_cur.rpend = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rdata = cur.re ? reg_rdata : `SPC_RST8;
    end
    if (rready && cur.rvalid) begin
      next_cur.rvalid = 1'b0;
    end
    next_cur.awready = !next_cur.aw_h && !next_cur.bvalid;
    next_cur.wready = !next_cur.w_h && !next_cur.bvalid;
    next_cur.arready = !next_cur.rpend && !next_cur.rvalid;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign awready = cur.awready;
  assign wready = cur.wready;
  assign bvalid = cur.bvalid;
  assign bresp = cur.bresp;
  assign arready = cur.arready;
  assign rvalid = cur.rvalid;
  assign rdata = {24'h000000, cur.rdata};
  assign rresp = cur.rresp;
  assign reg_we = cur.we;
  assign reg_widx = cur.widx;
  assign reg_wdata = cur.wd;
  assign reg_re = cur.re;
  assign reg_ridx = cur.ridx;
endmodule
`default_nettype wire

// file: dv/spc_spi_client.sv
// behavioural spi client facing the core when it is host
// assumes the bench gives select, mode and the byte to return
`timescale 1ns/1ns
`default_nettype none
module spc_spi_client (
  // serial wires
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  output logic miso,
  // setup and results
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output int cnt
);
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    cnt = 0;
  end
  always @(negedge sel_b) begin
    cnt = 0;
    miso = lsb ? tx[0] : tx[7];
  end
  // a released line shows the inverse of its last bit
  always @(posedge sel_b) miso = ~miso;
  always @(sck) begin
    if (!sel_b && sck === (cpol ~^ cpha)) begin
      // the count runs on over every byte of one select frame
      rx[lsb ? cnt % 8 : 7 - cnt % 8] = mosi;
      cnt = cnt + 1;
    end else if (!sel_b) begin
      miso = lsb ? tx[cnt % 8] : tx[7 - cnt % 8];
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_spc_core.sv
// self-checking bench for the serial port core in host mode
// assumes the core's register map at four times the index
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.svh"
module tb_spc_core;
  localparam logic [7:0] AA = 8'h00, AB = 8'h04, AI = 8'h08, AF = 8'h0c, AD = 8'h10;
  logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ss_b = 1, cs_b = 1, pol = 0, pha = 0, lsb = 0, sq = 0, eq = 0;
  logic [7:0] awaddr = 0, araddr = 0, ptx = 0, prx;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, sck_event, irq, miso;
  int n_fail = 0, check_count = 0, cyc = 0, lastc = 0, gap = 0, evrun = 0, evmin = 99, pcnt;
  wire sck_w = sck_oe ? sck_out : pol;
  wire mosi_w = mosi_oe ? mosi_out : ~mosi_out;
  wire miso_w = miso_oe ? miso_out : miso;
  always #25 clk = ~clk;
  spc_core #(.AW(8)) uut (.clk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
    .miso_in(miso_w), .miso_out, .miso_oe, .select_b_in(ss_b), .sck_event, .irq);
  spc_spi_client peer (.sck(sck_w), .mosi(mosi_w), .sel_b(cs_b), .miso(miso), .cpol(pol),
    .cpha(pha), .lsb(lsb), .tx(ptx), .rx(prx), .cnt(pcnt));
  // half period of the serial clock and shortest event level
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sq <= sck_out;
    eq <= sck_event;
    if (sck_out !== sq) begin
      gap <= cyc - lastc;
      lastc <= cyc;
    end
    if (sck_event !== eq) begin
      if (rst_b && evrun < evmin) evmin <= evrun;
      evrun <= 1;
    end else evrun <= evrun + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 0;
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    araddr <= a;
    arvalid <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 0;
    d = rdata[7:0];
    rsp = rresp;
  endtask
  task automatic regs;
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), d);
      chk("reset value", d, 0);
    end
    rd(8'h14, d);
    chk("unmapped", rsp, `SPC_RESP_ERR);
    wr(AA, 8'hff);
    rd(AA, d);
    chk("ctla mask", d, `SPC_A_MASK);
    wr(AB, 8'hff);
    rd(AB, d);
    chk("ctlb mask", d, `SPC_B_MASK);
    wr(AA, 8'h00);
    wr(AB, 8'h00);
  endtask
  task automatic xfer(input logic [1:0] m, input logic o, input logic [1:0] p, input logic x,
      input logic [7:0] t, input logic [7:0] r, input logic col);
    logic [7:0] f;
    int h;
    h = (p == 0 ? 2 : p == 1 ? 8 : p == 2 ? 32 : 64) >> x;
    pol <= m[1];
    pha <= m[0];
    lsb <= o;
    ptx <= r;
    wr(AI, 8'h01);
    wr(AB, {6'h0, m});
    wr(AA, {1'b0, o, 1'b1, x, 1'b0, p, 1'b1});
    cs_b <= 0;
    wr(AD, t);
    if (col) wr(AD, ~t);
    f = 0;
    for (int i = 0; i < 2000 && !f[7]; i++) rd(AF, f);
    chk("flags", f, col ? 8'hc0 : 8'h80);
    chk("irq", irq, 1);
    chk("sck idle", sck_out, m[1]);
    chk("sent", prx, t);
    chk("bits", pcnt, 8);
    chk("half period", gap, h);
    rd(AD, f);
    chk("received", f, r);
    rd(AF, f);
    chk("cleared", f, 0);
    chk("irq off", irq, 0);
    cs_b <= 1;
  endtask
  task automatic loss;
    logic [7:0] d;
    wr(AB, 8'h00);
    wr(AA, 8'h21);
    ss_b <= 0;
    repeat (4) @(posedge clk);
    rd(AA, d);
    chk("host dropped", d, 8'h01);
    rd(AF, d);
    chk("drop flag", d, 8'h80);
    ss_b <= 1;
    rd(AD, d);
    wr(AB, 8'h04);
    wr(AA, 8'h21);
    ss_b <= 0;
    repeat (4) @(posedge clk);
    rd(AA, d);
    chk("host kept", d, 8'h21);
    ss_b <= 1;
  endtask
  task automatic bufd(input logic w, input logic [7:0] t, input logic [7:0] r);
    logic [7:0] f;
    pol <= 0;
    pha <= 0;
    lsb <= 0;
    ptx <= r;
    wr(AB, {1'b1, w, 6'h00});
    wr(AF, 8'hd1);
    wr(AI, 8'h80);
    cs_b <= 0;
    wr(AD, t);
    f = 0;
    for (int i = 0; i < 2000 && !f[6]; i++) rd(AF, f);
    chk("buf flags", f, {2'h3, !w, 5'h00});
    chk("buf irq", irq, 1);
    chk("buf sent", prx, t);
    chk("buf bits", pcnt, w ? 8 : 16);
    rd(AD, f);
    chk("buf received", f, r);
    rd(AF, f);
    chk("buf left", f, {!w, 1'b1, !w, 5'h00});
    chk("buf irq left", irq, !w);
    cs_b <= 1;
  endtask
  task end_sim;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    regs;
    xfer(2'h0, 0, 2'h0, 0, 8'h1e, 8'h4b, 0);
    xfer(2'h1, 1, 2'h1, 1, 8'h35, 8'h8c, 0);
    xfer(2'h2, 0, 2'h2, 0, 8'hd2, 8'h61, 0);
    xfer(2'h3, 1, 2'h3, 1, 8'h07, 8'he9, 0);
    xfer(2'h0, 0, 2'h0, 1, 8'h9c, 8'h36, 1);
    loss;
    bufd(1, 8'h5a, 8'hc3);
    bufd(0, 8'ha7, 8'h3c);
    chk("event level", evmin >= 2, 1);
    end_sim;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
